// ===== hw/fidr_core.sv
/*
  Identification and parameter read-back command interpreter of a serial flash.
  Assumes link pins arrive asynchronously and are synchronised here; the
  link clock is sampled by clk_in, which must run well above it.
*/
// What this block does
// - Read-param command returns the volatile read register
// - Ext-param command returns volatile extended register
// - Ext-param read works during write in progress
// - Clear command zeroes the three error flags
// - Error flags stay set until clear command
// - Legacy ID: opcode, three dummies, ID MSB first
// - Legacy ID byte repeats until select rises
// - Standard ID: maker byte then two-byte code
// - Standard ID three bytes loop while selected
// - Address bit zero picks maker or device first
// - Maker and device bytes alternate while selected
// - Unique ID: address, dummies, sixteen bytes out
// - Sixteen unique bytes repeat cyclically
// - Address bits three to zero pick start
// - Table read: address, eight dummies, data out
// - Quad mode table read also has eight dummies
// - Undefined table addresses return any value
// - No-op only cancels pending reset arm
// - Legacy ID accepted in single and quad
// - No-op recognised in single and quad
// - Any non-reset command cancels reset arm
// - Legacy ID ignored while write in progress
`timescale 1ns/1ps
module fidr_core
  import fidr_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5A,      // Arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h21,     // Arbitrary value
  parameter logic [15:0] TYPE_CAP_CODE = 16'h4321, // Arbitrary value
  parameter logic [127:0] UNIQUE_NUM = 128'h0123456789ABCDEF_FEDCBA9876543210
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sclk_in,
  input wire logic csn_in,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out,
  input wire logic quad_command_mode_in,
  input wire logic [7:0] read_param_in,
  input wire logic [7:0] ext_param_in,
  input wire logic write_in_progress_flag_in,
  input wire logic prot_err_set_in,
  input wire logic prog_err_set_in,
  input wire logic erase_err_set_in,
  input wire logic [4:0] uid_dummy_clks_in,
  input wire logic tbl_wr_en_in,
  input wire logic [7:0] tbl_wr_addr_in,
  input wire logic [7:0] tbl_wr_data_in,
  output logic [2:0] err_flags_out,
  output logic reset_armed_out,
  output logic reset_go_out,
  output logic release_pd_out
);
  import fidr_pkg::*;

  logic [2:0] sclk_s_q, csn_s_q;
  logic [3:0] io_s1_q, io_s2_q;
  logic sclk_rise, sclk_fall, cs_active, cs_end;
  logic quad;
  fidr_state_type state_q;
  fidr_src_type src_q;
  logic [7:0] sh_in_q;
  logic [2:0] bit_cnt_q;
  logic [2:0] byte_cnt_q;
  logic [4:0] dummy_cnt_q;
  logic [23:0] addr_q;
  logic [7:0] opcode_q;
  logic [7:0] out_byte_q;
  logic [2:0] out_bit_q;
  logic [3:0] out_idx_q;
  logic [7:0] tbl_addr_q;
  logic [7:0] tbl_data;
  logic [2:0] err_q;
  logic armed_q;
  logic [7:0] in_byte;
  logic byte_done;
  logic [2:0] bits_per_byte;
  logic [7:0] next_byte;

  // Two stages plus an edge-history bit; only the second and third are read
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_s_q <= 3'h0;
      csn_s_q <= 3'h7;
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk_in};
      csn_s_q <= {csn_s_q[1:0], csn_in};
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
    end
  end

  assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
  assign cs_active = ~csn_s_q[1];
  assign cs_end = csn_s_q[1] & ~csn_s_q[2];
  assign quad = quad_command_mode_in;
  // Quad moves a nibble per clock, single one bit
  assign bits_per_byte = quad ? 3'h1 : 3'h7;
  assign in_byte = quad ? {sh_in_q[3:0], io_s2_q} : {sh_in_q[6:0], io_s2_q[0]};
  assign byte_done = sclk_rise && (bit_cnt_q == bits_per_byte);

  // Byte assembly on rising edges; select high flushes it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sh_in_q <= 8'h00;
      bit_cnt_q <= 3'h0;
    end else if (!cs_active) begin
      bit_cnt_q <= 3'h0;
    end else if (sclk_rise) begin
      sh_in_q <= in_byte;
      bit_cnt_q <= byte_done ? 3'h0 : bit_cnt_q + 3'h1;
    end
  end

  // Selects the response byte for a given index
  always_comb begin
    next_byte = 8'h00;
    case (src_q)
      SRC_RP: next_byte = read_param_in;
      SRC_ERP: next_byte = {ext_param_in[7:4], err_q, write_in_progress_flag_in};
      SRC_LEG: next_byte = DEVICE_CODE;
      SRC_STD: begin
        case (out_idx_q[1:0])
          2'h0: next_byte = MAKER_CODE;
          2'h1: next_byte = TYPE_CAP_CODE[15:8];
          default: next_byte = TYPE_CAP_CODE[7:0];
        endcase
      end
      SRC_MD: next_byte = (out_idx_q[0] ^ addr_q[0]) ? DEVICE_CODE : MAKER_CODE;
      SRC_UID: next_byte = UNIQUE_NUM[8'(127 - 8 * out_idx_q) -: 8];
      SRC_TBL: next_byte = tbl_data;
      default: next_byte = 8'h00;
    endcase
  end

  // Decoder: opcode, preamble, dummy clocks, then output until select rises
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_OPCODE;
      src_q <= SRC_RP;
      byte_cnt_q <= 3'h0;
      dummy_cnt_q <= 5'h00;
      addr_q <= 24'h000000;
      opcode_q <= 8'h00;
    end else if (!cs_active) begin
      state_q <= ST_OPCODE;
      // Forget the opcode so an empty frame cannot fire a stale release pulse
      opcode_q <= 8'h00;
    end else begin
      case (state_q)
        ST_OPCODE: begin
          if (byte_done) begin
            opcode_q <= in_byte;
            byte_cnt_q <= 3'h0;
            addr_q <= 24'h000000;
            case (in_byte)
              OP_READ_PARAM: begin
                src_q <= SRC_RP;
                state_q <= ST_OUT;
              end
              OP_EXT_PARAM: begin
                src_q <= SRC_ERP;
                state_q <= ST_OUT;
              end
              OP_LEGACY_ID: begin
                src_q <= SRC_LEG;
                state_q <= write_in_progress_flag_in ? ST_IGNORE : ST_PRE;
              end
              OP_STD_ID_SINGLE, OP_STD_ID_QUAD: begin
                src_q <= SRC_STD;
                state_q <= ((in_byte == OP_STD_ID_QUAD) == quad) ? ST_OUT : ST_IGNORE;
              end
              OP_MAKER_DEV_ID: begin
                src_q <= SRC_MD;
                state_q <= ST_PRE;
              end
              OP_UNIQUE_NUM: begin
                src_q <= SRC_UID;
                state_q <= ST_PRE;
              end
              OP_PARAM_TABLE: begin
                src_q <= SRC_TBL;
                state_q <= ST_PRE;
              end
              default: state_q <= ST_IGNORE;
            endcase
          end
        end
        ST_PRE: begin
          if (byte_done) begin
            addr_q <= {addr_q[15:0], in_byte};
            byte_cnt_q <= byte_cnt_q + 3'h1;
            if (byte_cnt_q == ADDR_BYTES - 3'h1) begin
              dummy_cnt_q <= 5'h00;
              // Legacy ID and maker/device read have no dummy clocks
              if (src_q == SRC_LEG || src_q == SRC_MD) begin
                state_q <= ST_OUT;
              end else begin
                state_q <= ST_DUMMY;
              end
            end
          end
        end
        ST_DUMMY: begin
          if (sclk_rise) begin
            dummy_cnt_q <= dummy_cnt_q + 5'h01;
            // Table read fixed at eight in both modes
            if (dummy_cnt_q + 5'h01 ==
                ((src_q == SRC_TBL) ? TABLE_DUMMY_CLKS : uid_dummy_clks_in)) begin
              state_q <= ST_OUT;
            end
          end
        end
        ST_OUT: state_q <= ST_OUT;
        ST_IGNORE: state_q <= ST_IGNORE;
        default: state_q <= ST_OPCODE;
      endcase
    end
  end

  // Output index and table address; first byte prepared on entry to output
  logic out_start, out_byte_end;
  logic [3:0] first_idx;
  assign first_idx = (src_q == SRC_UID) ? addr_q[3:0] : 4'h0;
  assign out_byte_end = sclk_fall && (out_bit_q == 3'h0) && (state_q == ST_OUT);
  logic in_out_prev_q;
  assign out_start = (state_q == ST_OUT) && !in_out_prev_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      in_out_prev_q <= 1'b0;
      out_idx_q <= 4'h0;
      tbl_addr_q <= 8'h00;
    end else begin
      in_out_prev_q <= (state_q == ST_OUT) && cs_active;
      if (out_start) begin
        out_idx_q <= first_idx;
        tbl_addr_q <= addr_q[7:0];
      end else if (out_byte_end) begin
        tbl_addr_q <= tbl_addr_q + 8'h01;
        // Index wraps per source
        if (src_q == SRC_STD && out_idx_q == 4'h2) begin
          out_idx_q <= 4'h0;
        end else begin
          out_idx_q <= out_idx_q + 4'h1;
        end
      end
    end
  end

  // Output shifter: bits change on falling edges, MSB first
  logic [1:0] load_pending_q;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_byte_q <= 8'h00;
      out_bit_q <= 3'h0;
      load_pending_q <= 2'b00;
      io_out <= 4'h0;
      io_oe_out <= 4'h0;
    end else if (!cs_active || state_q != ST_OUT) begin
      io_oe_out <= 4'h0;
      load_pending_q <= 2'b00;
      // Pointer parks on the top bit, so the first fall sends the MSB
      out_bit_q <= bits_per_byte;
    end else begin
      // Two stages: the index or table address moves, then the table read settles
      load_pending_q <= {load_pending_q[0], out_start || out_byte_end};
      if (sclk_fall) begin
        if (out_bit_q == 3'h0) begin
          out_bit_q <= bits_per_byte;
        end else begin
          out_bit_q <= out_bit_q - 3'h1;
        end
        if (quad) begin
          io_out <= (out_bit_q == 3'h1) ? out_byte_q[7:4] : out_byte_q[3:0];
          io_oe_out <= 4'hF;
        end else begin
          io_out <= {2'b00, out_byte_q[out_bit_q], 1'b0};
          io_oe_out <= 4'h2;
        end
      end
      // Last bit of the old byte has left by now, so replacing it is safe
      if (load_pending_q[1]) begin
        out_byte_q <= next_byte;
      end
    end
  end

  // Sticky errors: set wins over the clear command
  logic clr_cmd;
  assign clr_cmd = (state_q == ST_OPCODE) && byte_done && (in_byte == OP_ERR_CLEAR);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      err_q <= 3'h0;
    end else begin
      err_q <= (clr_cmd ? 3'h0 : err_q) |
               {erase_err_set_in, prog_err_set_in, prot_err_set_in};
    end
  end

  // Reset arm: armed by arm command, any other opcode drops it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      armed_q <= 1'b0;
      reset_go_out <= 1'b0;
      release_pd_out <= 1'b0;
    end else begin
      reset_go_out <= 1'b0;
      release_pd_out <= 1'b0;
      if (state_q == ST_OPCODE && byte_done) begin
        armed_q <= (in_byte == OP_RESET_ARM);
        reset_go_out <= armed_q && (in_byte == OP_RESET_GO);
      end
      if (cs_end && opcode_q == OP_LEGACY_ID && !write_in_progress_flag_in) begin
        release_pd_out <= 1'b1;
      end
    end
  end

  assign err_flags_out = err_q;
  assign reset_armed_out = armed_q;

  fidr_table_rom #(
    .DEPTH(TABLE_DEPTH)
  ) u_table (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .addr_in(tbl_wr_en_in ? tbl_wr_addr_in : tbl_addr_q),
    .wr_en_in(tbl_wr_en_in),
    .wr_data_in(tbl_wr_data_in),
    .rd_data_out(tbl_data)
  );

  // Protection error flag (bit 0) never drops without the clear command
  a_err_sticky: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (err_q[0] && !clr_cmd) |=> err_q[0])
    else $error("error flag dropped without clear");
  a_err_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (clr_cmd && !prot_err_set_in) |=> !err_q[0])
    else $error("clear did not zero flag");
  a_arm_cancel: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_q == ST_OPCODE && byte_done && in_byte == OP_NO_OP) |=> !armed_q)
    else $error("no-op left reset armed");
  a_abort_oe: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !cs_active |=> io_oe_out == 4'h0)
    else $error("drive kept after deselect");
  a_abort_state: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !cs_active |=> state_q == ST_OPCODE)
    else $error("decoder not reset on deselect");
  a_wip_legacy: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_q == ST_OPCODE && byte_done && in_byte == OP_LEGACY_ID
     && write_in_progress_flag_in && cs_active) |=> state_q == ST_IGNORE)
    else $error("legacy id accepted while busy");
  a_ext_busy: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state_q == ST_OPCODE && byte_done && in_byte == OP_EXT_PARAM && cs_active)
    |=> state_q == ST_OUT)
    else $error("ext param read refused");
  a_std_wrap: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (src_q == SRC_STD && in_out_prev_q) |-> out_idx_q <= 4'h2)
    else $error("standard id index out of range");
endmodule

// ===== shared/fidr_pkg.sv
/*
  Constants for the flash identification and parameter read-back block.
  Assumes a single system clock; the serial link clock is sampled, not used as a clock.
*/
package fidr_pkg;
  // Opcodes
  localparam logic [7:0] OP_READ_PARAM = 8'h61;
  localparam logic [7:0] OP_EXT_PARAM = 8'h81;
  localparam logic [7:0] OP_ERR_CLEAR = 8'h82;
  localparam logic [7:0] OP_LEGACY_ID = 8'hAB;
  localparam logic [7:0] OP_STD_ID_SINGLE = 8'h9F;
  localparam logic [7:0] OP_STD_ID_QUAD = 8'hAF;
  localparam logic [7:0] OP_MAKER_DEV_ID = 8'h90;
  localparam logic [7:0] OP_UNIQUE_NUM = 8'h4B;
  localparam logic [7:0] OP_PARAM_TABLE = 8'h5A;
  localparam logic [7:0] OP_NO_OP = 8'h00;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_GO = 8'h99;
  // Extended read register error and busy bit positions
  localparam int PROT_ERR_BIT = 1;
  localparam int PROG_ERR_BIT = 2;
  localparam int ERASE_ERR_BIT = 3;
  localparam int WIP_BIT = 0;
  // Byte counts of the preamble (after the opcode), dummy clock counts and sizes
  localparam logic [2:0] LEGACY_DUMMY_BYTES = 3'h3;
  localparam logic [2:0] MDID_PRE_BYTES = 3'h3;
  localparam logic [2:0] ADDR_BYTES = 3'h3;
  localparam logic [4:0] TABLE_DUMMY_CLKS = 5'h08;
  localparam logic [4:0] UID_DUMMY_DEFAULT = 5'h08;
  localparam int UID_BYTES = 16;
  localparam int TABLE_DEPTH = 256;
  // Command decoder states
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_PRE = 3'b001,
    ST_DUMMY = 3'b010,
    ST_OUT = 3'b011,
    ST_IGNORE = 3'b100
  } fidr_state_type;
  // Response sources
  typedef enum logic [2:0] {
    SRC_RP = 3'b000,
    SRC_ERP = 3'b001,
    SRC_LEG = 3'b010,
    SRC_STD = 3'b011,
    SRC_MD = 3'b100,
    SRC_UID = 3'b101,
    SRC_TBL = 3'b110
  } fidr_src_type;
endpackage

// ===== hw/fidr_table_rom.sv
/*
  Small table memory holding the discoverable-parameter table.
  Assumes the same clock as the command decoder; read data is registered.
*/
`timescale 1ns/1ps
module fidr_table_rom #(
  parameter int DEPTH = 256
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem_q [DEPTH];

  // Loadable at system bring-up; unwritten entries are undefined content
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_q[addr_in] <= wr_data_in;
    end
  end

  // Registered read port
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= mem_q[addr_in];
    end
  end
endmodule

// ===== sim/fidr_host_model.sv
/*
  Host-side link model: drives select, link clock and data, samples replies.
  Assumes the bench wires its io_out to the core and the core's io pins back.
*/
`timescale 1ns/1ps
module fidr_host_model (
  output logic sclk_out,
  output logic csn_out,
  output logic [3:0] io_out,
  input wire logic [3:0] dev_io_in,
  input wire logic [3:0] dev_oe_in,
  input wire logic quad_in
);
  logic [3:0] drv_q;
  // Line level: the core wins where it drives, else the host pattern
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_out[i] = dev_oe_in[i] ? dev_io_in[i] : drv_q[i];
    end
  end
  // Idle: select high, link clock parked low between frames
  initial begin
    sclk_out = 1'b0;
    csn_out = 1'b1;
    drv_q = 4'h0;
  end
  // One 48 ns link clock: data set in the low phase, sampled at the rise
  task automatic tick(input logic [3:0] v, output logic [3:0] s);
    drv_q = v;
    #24;
    sclk_out = 1'b1;
    s = io_out;
    #24;
    sclk_out = 1'b0;
  endtask
  // Opcode, address and dummy bytes go MSB first at the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    logic [3:0] s;
    if (quad_in) begin
      tick(tx[7:4], s);
      rx[7:4] = s;
      tick(tx[3:0], s);
      rx[3:0] = s;
    end else begin
      for (int i = 7; i >= 0; i--) begin
        tick({~drv_q[3:1], tx[i]}, s);
        rx[i] = s[1];
      end
    end
  endtask
  // Dummy clocks carry nothing, so every line flips each clock
  task automatic dummy(input int n);
    logic [3:0] s;
    repeat (n) tick(~drv_q, s);
  endtask
  task automatic open_frame();
    csn_out = 1'b0;
  endtask
  // Select rises half a clock after the last fall, then a gap
  task automatic close_frame();
    #24;
    csn_out = 1'b1;
    #72;
  endtask
endmodule

// ===== sim/fidr_core_tb.sv
/*
  Self-checking bench for the identification and read-back core.
  Assumes fidr_pkg and the host link model are compiled first.
*/
`timescale 1ns/1ps
module fidr_core_tb;
  import fidr_pkg::*;
  localparam logic [7:0] MK = 8'hC3; // Arbitrary value
  localparam logic [7:0] DV = 8'h4E; // Arbitrary value
  localparam logic [15:0] TC = 16'hB7D2; // Arbitrary value
  // Mirrored bytes, so either byte numbering reads the same
  localparam logic [127:0] UID = 128'h1122334455667788_8877665544332211;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic quad = 1'b0;
  logic write_in_progress_flag = 1'b0;
  logic pr_set = 1'b0;
  logic pg_set = 1'b0;
  logic er_set = 1'b0;
  logic [4:0] uid_dum = 5'h08;
  logic tw_en = 1'b0;
  logic [7:0] tw_addr = 8'h00;
  logic [7:0] tw_data = 8'h00;
  logic sclk, csn, armed, go, rel;
  logic [3:0] io_lnk, io_o, oe;
  logic [2:0] err;
  logic [7:0] rx;
  int failures = 0;
  int n_compared = 0;
  int rel_cnt = 0;
  int go_cnt = 0;

  fidr_core #(
    .MAKER_CODE(MK),
    .DEVICE_CODE(DV),
    .TYPE_CAP_CODE(TC),
    .UNIQUE_NUM(UID)
  ) u_fidr_core (
    .clk_in(clk),
    .nrst_in(nrst),
    .sclk_in(sclk),
    .csn_in(csn),
    .io_in(io_lnk),
    .io_out(io_o),
    .io_oe_out(oe),
    .quad_command_mode_in(quad),
    .read_param_in(8'hA5),
    .ext_param_in(8'h96),
    .write_in_progress_flag_in(write_in_progress_flag),
    .prot_err_set_in(pr_set),
    .prog_err_set_in(pg_set),
    .erase_err_set_in(er_set),
    .uid_dummy_clks_in(uid_dum),
    .tbl_wr_en_in(tw_en),
    .tbl_wr_addr_in(tw_addr),
    .tbl_wr_data_in(tw_data),
    .err_flags_out(err),
    .reset_armed_out(armed),
    .reset_go_out(go),
    .release_pd_out(rel)
  );
  fidr_host_model u_fidr_host_model (
    .sclk_out(sclk),
    .csn_out(csn),
    .io_out(io_lnk),
    .dev_io_in(io_o),
    .dev_oe_in(oe),
    .quad_in(quad)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end
  // Pulses last one cycle, so they are counted rather than sampled
  always @(posedge clk) begin
    if (rel === 1'b1) rel_cnt <= rel_cnt + 1;
    if (go === 1'b1) go_cnt <= go_cnt + 1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic set_mode(input logic q);
    @(negedge clk);
    quad = q;
  endtask
  task automatic cmd(input logic [7:0] op, input int n, input logic [23:0] a, input int d);
    u_fidr_host_model.open_frame();
    u_fidr_host_model.xfer(op, rx);
    for (int i = 0; i < n; i++) begin
      u_fidr_host_model.xfer(a[23 - 8 * i -: 8], rx);
    end
    u_fidr_host_model.dummy(d);
  endtask
  task automatic get();
    u_fidr_host_model.xfer(8'h55, rx);
  endtask
  // Select high must drop every driver, whatever was in flight
  task automatic fin();
    u_fidr_host_model.close_frame();
    check({4'h0, oe}, 8'h00);
  endtask
  task automatic op_only(input logic [7:0] op);
    cmd(op, 0, 24'h0, 0);
    fin();
  endtask

  task automatic t_read_param();
    for (int q = 0; q < 2; q++) begin
      set_mode(q[0]);
      cmd(OP_READ_PARAM, 0, 24'h0, 0);
      repeat (2) begin
        get();
        check(rx, 8'hA5);
      end
      check({4'h0, oe}, q ? 8'h0F : 8'h02);
      fin();
    end
  endtask
  // Error flags and busy bit merge into the extended byte: 9h,5h,1
  task automatic t_ext_param();
    set_mode(1'b0);
    pr_set = 1'b1;
    er_set = 1'b1;
    write_in_progress_flag = 1'b1;
    @(negedge clk);
    pr_set = 1'b0;
    er_set = 1'b0;
    cmd(OP_EXT_PARAM, 0, 24'h0, 0);
    get();
    check(rx, 8'h9B);
    fin();
    op_only(OP_NO_OP);
    check({5'h00, err}, 8'h05);
    @(negedge clk);
    write_in_progress_flag = 1'b0;
    pg_set = 1'b1;
    @(negedge clk);
    pg_set = 1'b0;
    op_only(OP_ERR_CLEAR);
    check({5'h00, err}, 8'h00);
  endtask
  // Third pass is busy: the command is ignored and nothing is driven
  task automatic t_legacy();
    int n0;
    for (int q = 0; q < 3; q++) begin
      set_mode(q == 1);
      write_in_progress_flag = (q == 2);
      n0 = rel_cnt;
      cmd(OP_LEGACY_ID, 3, 24'hFFFFFF, 0);
      repeat (2) begin
        get();
        if (q < 2) check(rx, DV);
      end
      if (q == 2) check({4'h0, oe}, 8'h00);
      fin();
      check(8'(rel_cnt - n0), {7'h0, q < 2});
    end
    write_in_progress_flag = 1'b0;
  endtask
  task automatic t_std_id();
    logic [7:0] e [4] = '{MK, TC[15:8], TC[7:0], MK};
    for (int q = 0; q < 2; q++) begin
      set_mode(q[0]);
      cmd(q ? OP_STD_ID_QUAD : OP_STD_ID_SINGLE, 0, 24'h0, 0);
      for (int i = 0; i < 4; i++) begin
        get();
        check(rx, e[i]);
      end
      fin();
    end
  endtask
  task automatic t_maker_dev();
    set_mode(1'b0);
    for (int a = 0; a < 2; a++) begin
      cmd(OP_MAKER_DEV_ID, 3, {16'hA5A5, 7'h55, a[0]}, 0);
      for (int i = 0; i < 3; i++) begin
        get();
        check(rx, (i[0] ^ a[0]) ? DV : MK);
      end
      fin();
    end
  endtask
  // Start at byte 14 so the read wraps; upper address bits are junk
  task automatic t_unique();
    for (int q = 0; q < 2; q++) begin
      set_mode(q[0]);
      uid_dum = q ? 5'h05 : 5'h08;
      cmd(OP_UNIQUE_NUM, 3, 24'hC7B00E, q ? 5 : 8);
      for (int i = 0; i < 3; i++) begin
        get();
        check(rx, UID[127 - 8 * ((14 + i) % 16) -: 8]);
      end
      fin();
    end
  endtask
  task automatic t_table();
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      tw_en = 1'b1;
      tw_addr = 8'h30 + 8'(i);
      tw_data = 8'hE1 + 8'(i * 17);
    end
    @(negedge clk);
    tw_en = 1'b0;
    for (int q = 0; q < 2; q++) begin
      set_mode(q[0]);
      cmd(OP_PARAM_TABLE, 3, 24'h000030, 8);
      for (int i = 0; i < 3; i++) begin
        get();
        check(rx, 8'hE1 + 8'(i * 17));
      end
      fin();
    end
  endtask
  task automatic t_reset();
    int g0;
    for (int q = 0; q < 2; q++) begin
      set_mode(q[0]);
      g0 = go_cnt;
      op_only(OP_RESET_ARM);
      check({7'h0, armed}, 8'h01);
      op_only(OP_NO_OP);
      check({7'h0, armed}, 8'h00);
      op_only(OP_RESET_ARM);
      op_only(OP_READ_PARAM);
      check({7'h0, armed}, 8'h00);
      op_only(OP_RESET_ARM);
      op_only(OP_RESET_GO);
      check(8'(go_cnt - g0), 8'h01);
    end
  endtask

  initial begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_read_param();
    t_ext_param();
    t_legacy();
    t_std_id();
    t_maker_dev();
    t_unique();
    t_table();
    t_reset();
    report_and_stop();
  end
  // The tests need about 29 us; allow well over ten times that
  initial begin
    #400000;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule
